/* logic/aux_pwm_map.vh */
// Register map, field positions, reset values and timing counts of the dual auxiliary PWM timer.
//
// Overview of operation
// - Two outputs, 8-bit period and on-time each.
// - Mode bit one selects independent mode.
// - Time step is two core clock cycles.
// - Output zero period is two times period0+1.
// - Mode bit one: output one period uses period1.
// - On-time is two times on-time value.
// - On-time above period gives full duty.
// - Mode bit zero: shared period from period0.
// - Offset mode keeps each own on-time register.
// - Output one rises offset after output zero.
// - New on-time applies at next cycle start.
// - Period write restarts timers; offset mode preloads timer one.
// - Reset clears mode bit: offset mode.
// - Reset sets both period registers to 0xFF.
// - Reset clears both on-time registers.
`ifndef AUX_PWM_MAP_VH
`define AUX_PWM_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_MODE_CONTROL 8'h00
`define OFS_PERIOD_ZERO 8'h04
`define OFS_PERIOD_ONE 8'h08
`define OFS_ONTIME_ZERO 8'h0C
`define OFS_ONTIME_ONE 8'h10
`define OFS_STATUS 8'h14

// ----------------------------------------------------------------------------
// Register indices and field positions
// ----------------------------------------------------------------------------
`define IDX_MODE_CONTROL 3'h0
`define IDX_PERIOD_ZERO 3'h1
`define IDX_PERIOD_ONE 3'h2
`define IDX_ONTIME_ZERO 3'h3
`define IDX_ONTIME_ONE 3'h4
`define IDX_STATUS 3'h5
`define IDX_NONE 3'h7
`define MODE_INDEP_BIT 8

// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define RST_MODE_INDEP 1'h0
`define RST_PERIOD 8'hFF
`define RST_ONTIME 8'h00
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

// ----------------------------------------------------------------------------
// Timing: core clock cycles per time step
// ----------------------------------------------------------------------------
`define STEP_CYCLES 2

`endif

/* logic/aux_pwm_channel.v */
// One auxiliary pulse-width channel: period timer, on-time latch and output flop.
`timescale 1ns/1ps

module aux_pwm_channel (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Time step and restart
	input wire step,
	input wire restart,
	// Settings
	input wire [7:0] period,
	input wire [7:0] ontime,
	input wire [7:0] load_value,
	// State
	output reg [7:0] count,
	output reg pwm_out
);

	// ------------------------------------------------------------------------
	// Timer and output
	// ------------------------------------------------------------------------
	reg [7:0] ontime_latched;
	reg started;
	wire [8:0] next_count;

	assign next_count = {1'b0, count} + 9'h001;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 8'h00;
			ontime_latched <= 8'h00;
			started <= 1'b1;
			pwm_out <= 1'b0;
		end else if (restart) begin
			// A nonzero load delays the first cycle start until the timer wraps.
			count <= load_value;
			if (load_value == 8'h00) begin
				ontime_latched <= ontime;
				started <= 1'b1;
				pwm_out <= (ontime != 8'h00);
			end else begin
				started <= 1'b0;
				pwm_out <= 1'b0;
			end
		end else if (step) begin
			if (count == period) begin
				count <= 8'h00;
				ontime_latched <= ontime;
				started <= 1'b1;
				pwm_out <= (ontime != 8'h00);
			end else begin
				count <= next_count[7:0];
				// An on-time beyond the period never ends inside the cycle.
				pwm_out <= started && (next_count < {1'b0, ontime_latched});
			end
		end
	end

endmodule // aux_pwm_channel

/* logic/dual_aux_pwm_timer.v */
// Dual auxiliary PWM timer with its AXI4-Lite register slave.
`timescale 1ns/1ps
`include "aux_pwm_map.vh"

module dual_aux_pwm_timer (
	// Clock and reset
	input wire REF_CLK,
	input wire RESET_N,
	// AXI4-Lite write address
	input wire [7:0] AWADDR,
	input wire [2:0] AWPROT,
	input wire AWVALID,
	output reg AWREADY,
	// AXI4-Lite write data
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output reg WREADY,
	// AXI4-Lite write response
	output reg [1:0] BRESP,
	output reg BVALID,
	input wire BREADY,
	// AXI4-Lite read address
	input wire [7:0] ARADDR,
	input wire [2:0] ARPROT,
	input wire ARVALID,
	output reg ARREADY,
	// AXI4-Lite read data
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	output reg RVALID,
	input wire RREADY,
	// Auxiliary outputs
	output wire AUX_OUT0,
	output wire AUX_OUT1
);

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	function [2:0] reg_index;
		input [7:0] addr;
		begin
			case (addr)
				`OFS_MODE_CONTROL: reg_index = `IDX_MODE_CONTROL;
				`OFS_PERIOD_ZERO: reg_index = `IDX_PERIOD_ZERO;
				`OFS_PERIOD_ONE: reg_index = `IDX_PERIOD_ONE;
				`OFS_ONTIME_ZERO: reg_index = `IDX_ONTIME_ZERO;
				`OFS_ONTIME_ONE: reg_index = `IDX_ONTIME_ONE;
				`OFS_STATUS: reg_index = `IDX_STATUS;
				default: reg_index = `IDX_NONE;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// Registers and internal state
	// ------------------------------------------------------------------------
	reg mode_indep;
	reg [7:0] aux_period0;
	reg [7:0] aux_period1;
	reg [7:0] aux_ontime0;
	reg [7:0] aux_ontime1;
	reg [7:0] awaddr_held;
	reg [31:0] wdata_held;
	reg [3:0] wstrb_held;
	reg restart;
	reg step_phase;
	wire [7:0] count0;
	wire [7:0] count1;
	wire write_go;
	wire [2:0] write_index;
	wire [2:0] read_index;
	wire [7:0] period_ch1;
	wire [7:0] load_ch1;
	reg [31:0] next_rdata;

	assign write_go = !AWREADY && !WREADY && !BVALID;
	assign write_index = reg_index(awaddr_held);
	assign read_index = reg_index(ARADDR);

	// ------------------------------------------------------------------------
	// Write channels
	// ------------------------------------------------------------------------
	// Address and data are held separately, so either may arrive first.
	always @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
			awaddr_held <= 8'h00;
			wdata_held <= 32'h00000000;
			wstrb_held <= 4'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				awaddr_held <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				wdata_held <= WDATA;
				wstrb_held <= WSTRB;
				WREADY <= 1'b0;
			end
			if (write_go) begin
				BVALID <= 1'b1;
				if (write_index == `IDX_NONE) begin
					BRESP <= `RESP_DECERR;
				end else begin
					BRESP <= `RESP_OKAY;
				end
			end
			if (BVALID && BREADY) begin
				BVALID <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	// Writes are taken at any time; period or mode writes restart both timers.
	always @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mode_indep <= `RST_MODE_INDEP;
			aux_period0 <= `RST_PERIOD;
			aux_period1 <= `RST_PERIOD;
			aux_ontime0 <= `RST_ONTIME;
			aux_ontime1 <= `RST_ONTIME;
			restart <= 1'b0;
		end else begin
			restart <= 1'b0;
			if (write_go) begin
				case (write_index)
					`IDX_MODE_CONTROL: begin
						if (wstrb_held[1]) begin
							mode_indep <= wdata_held[`MODE_INDEP_BIT];
							restart <= 1'b1;
						end
					end
					`IDX_PERIOD_ZERO: begin
						if (wstrb_held[0]) begin
							aux_period0 <= wdata_held[7:0];
							restart <= 1'b1;
						end
					end
					`IDX_PERIOD_ONE: begin
						if (wstrb_held[0]) begin
							aux_period1 <= wdata_held[7:0];
							restart <= 1'b1;
						end
					end
					`IDX_ONTIME_ZERO: begin
						if (wstrb_held[0]) begin
							aux_ontime0 <= wdata_held[7:0];
						end
					end
					`IDX_ONTIME_ONE: begin
						if (wstrb_held[0]) begin
							aux_ontime1 <= wdata_held[7:0];
						end
					end
					default: begin
						restart <= 1'b0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Read channels
	// ------------------------------------------------------------------------
	always @* begin
		next_rdata = 32'h00000000;
		case (read_index)
			`IDX_MODE_CONTROL: next_rdata[`MODE_INDEP_BIT] = mode_indep;
			`IDX_PERIOD_ZERO: next_rdata[7:0] = aux_period0;
			`IDX_PERIOD_ONE: next_rdata[7:0] = aux_period1;
			`IDX_ONTIME_ZERO: next_rdata[7:0] = aux_ontime0;
			`IDX_ONTIME_ONE: next_rdata[7:0] = aux_ontime1;
			`IDX_STATUS: next_rdata = {8'h00, count1, count0, 6'h00, AUX_OUT1, AUX_OUT0};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `RESP_OKAY;
		end else begin
			if (ARVALID && ARREADY) begin
				ARREADY <= 1'b0;
				RVALID <= 1'b1;
				RDATA <= next_rdata;
				if (read_index == `IDX_NONE) begin
					RRESP <= `RESP_DECERR;
				end else begin
					RRESP <= `RESP_OKAY;
				end
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
				ARREADY <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Time step divider
	// ------------------------------------------------------------------------
	// A restart realigns the step so every new cycle lasts whole steps.
	always @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			step_phase <= 1'b0;
		end else if (restart) begin
			step_phase <= 1'b0;
		end else begin
			step_phase <= ~step_phase;
		end
	end

	// ------------------------------------------------------------------------
	// Mode selection for the second channel
	// ------------------------------------------------------------------------
	// In offset mode the second timer shares the first period and starts
	// preloaded so that it wraps period1+1 steps after the first one. With
	// period1 not below period0 the offset collapses to zero.
	assign period_ch1 = mode_indep ? aux_period1 : aux_period0;
	assign load_ch1 = (mode_indep || (aux_period1 >= aux_period0)) ? 8'h00 :
		(aux_period0 - aux_period1);

	// ------------------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------------------
	aux_pwm_channel u_channel0 (
		.clk(REF_CLK),
		.reset_n(RESET_N),
		.step(step_phase),
		.restart(restart),
		.period(aux_period0),
		.ontime(aux_ontime0),
		.load_value(8'h00),
		.count(count0),
		.pwm_out(AUX_OUT0)
	);

	aux_pwm_channel u_channel1 (
		.clk(REF_CLK),
		.reset_n(RESET_N),
		.step(step_phase),
		.restart(restart),
		.period(period_ch1),
		.ontime(aux_ontime1),
		.load_value(load_ch1),
		.count(count1),
		.pwm_out(AUX_OUT1)
	);

endmodule // dual_aux_pwm_timer

/* sim/aux_pwm_chk.sv */
// Port checker for the dual auxiliary PWM timer.
`timescale 1ns/1ps

module aux_pwm_chk (
	// Clock and reset
	input wire REF_CLK,
	input wire RESET_N,
	// Bus handshakes
	input wire AWVALID,
	input wire AWREADY,
	input wire WVALID,
	input wire WREADY,
	input wire [1:0] BRESP,
	input wire BVALID,
	input wire BREADY,
	input wire ARVALID,
	input wire ARREADY,
	input wire [31:0] RDATA,
	input wire RVALID,
	input wire RREADY,
	// Outputs
	input wire AUX_OUT0,
	input wire AUX_OUT1
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);

	AST_W_LAT: assert property (
		AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID) else $error("late write answer");
	AST_B_HOLD: assert property (
		BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write answer dropped");
	AST_AW_BUSY: assert property (
		AWVALID && AWREADY |=> !AWREADY) else $error("second address taken");
	AST_R_LAT: assert property (
		ARVALID && ARREADY |=> RVALID) else $error("late read answer");
	AST_R_HOLD: assert property (
		RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read data dropped");
	AST_RESP: assert property (
		BVALID |-> BRESP == 2'h0 || BRESP == 2'h3) else $error("bad write code");
	AST_HI0: assert property (
		$rose(AUX_OUT0) |=> AUX_OUT0 || BVALID) else $error("short high on out0");
	AST_HI1: assert property (
		$rose(AUX_OUT1) |=> AUX_OUT1 || BVALID) else $error("short high on out1");
	AST_LO0: assert property (
		$fell(AUX_OUT0) |=> !AUX_OUT0 || BVALID) else $error("short low on out0");
	C_R0: cover property ($rose(AUX_OUT0));
	C_R1: cover property ($rose(AUX_OUT1));
	C_ERR: cover property (BVALID && BRESP == 2'h3);
endmodule // aux_pwm_chk

bind dual_aux_pwm_timer aux_pwm_chk u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
	.AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
	.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
	.AUX_OUT0(AUX_OUT0), .AUX_OUT1(AUX_OUT1));

/* sim/aux_pwm_load.sv */
// Load on one output pin: measures period, high time and rise moment.
`timescale 1ns/1ps

module aux_pwm_load (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Observed pin
	input wire sig,
	// Measurements in clock cycles
	output reg [31:0] per,
	output reg [31:0] hi,
	output reg [31:0] rise
);
	reg [31:0] cyc;
	reg last;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cyc <= 32'h0;
			last <= 1'b0;
			per <= 32'h0;
			hi <= 32'h0;
			rise <= 32'h0;
		end else begin
			cyc <= cyc + 32'h1;
			last <= sig;
			if (sig && !last) begin
				per <= cyc - rise;
				rise <= cyc;
			end
			if (!sig && last)
				hi <= cyc - rise;
		end
	end
endmodule // aux_pwm_load

/* sim/dual_aux_pwm_timer_tb.sv */
// Self-checking bench for the dual auxiliary PWM timer.
`timescale 1ns/1ps
`include "aux_pwm_map.vh"

module dual_aux_pwm_timer_tb;
	reg REF_CLK, RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	reg [7:0] AWADDR, ARADDR;
	reg [31:0] WDATA;
	wire AWREADY, WREADY, BVALID, ARREADY, RVALID, AUX_OUT0, AUX_OUT1;
	wire [1:0] BRESP, RRESP;
	wire [31:0] RDATA, per0, hi0, rise0, per1, hi1, rise1;
	int fails, n_checks, i, p0, p1, o0, o1;
	logic [31:0] d;
	logic [1:0] r;

	dual_aux_pwm_timer dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .AWADDR(AWADDR),
		.AWPROT(3'h0), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
		.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .AUX_OUT0(AUX_OUT0), .AUX_OUT1(AUX_OUT1));
	aux_pwm_load ld0 (.clk(REF_CLK), .reset_n(RESET_N), .sig(AUX_OUT0), .per(per0), .hi(hi0),
		.rise(rise0));
	aux_pwm_load ld1 (.clk(REF_CLK), .reset_n(RESET_N), .sig(AUX_OUT1), .per(per1), .hi(hi1),
		.rise(rise1));

	function automatic logic [31:0] per_of(input int p);
		return 32'(2 * (p + 1));
	endfunction

	task report_and_stop;
		if (fails == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ah, wh, bh;
		// Let one edge pass so BREADY is never driven twice in one time step.
		@(posedge REF_CLK);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		bh = 1'b0;
		for (int n = 0; n < 50 && !bh; n++) begin
			@(negedge REF_CLK);
			ah = AWVALID && AWREADY;
			wh = WVALID && WREADY;
			bh = BVALID;
			r = BRESP;
			@(posedge REF_CLK);
			if (ah) AWVALID <= 1'b0;
			if (wh) WVALID <= 1'b0;
			if (bh) BREADY <= 1'b0;
		end
		if (!bh) begin
			fails++;
			report_and_stop();
		end
	endtask

	task rdr(input logic [7:0] a);
		logic ah, rh;
		// Let one edge pass so RREADY is never driven twice in one time step.
		@(posedge REF_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		rh = 1'b0;
		for (int n = 0; n < 50 && !rh; n++) begin
			@(negedge REF_CLK);
			ah = ARVALID && ARREADY;
			rh = RVALID;
			d = RDATA;
			r = RRESP;
			@(posedge REF_CLK);
			if (ah) ARVALID <= 1'b0;
			if (rh) RREADY <= 1'b0;
		end
		if (!rh) begin
			fails++;
			report_and_stop();
		end
	endtask

	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end

	initial begin
		{RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
		{AWADDR, ARADDR, WDATA} = 48'h0;
		fails = 0;
		n_checks = 0;
		i = $urandom(28488);
		repeat (16) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		@(posedge REF_CLK);
		for (i = 0; i < 5; i++) begin
			rdr(8'(4 * i));
			chk("reset value", d, (i == 1 || i == 2) ? 32'hFF : 32'h0);
			chk("read code", 32'(r), 32'h0);
		end
		chk("idle outputs", 32'({AUX_OUT1, AUX_OUT0}), 32'h0);
		wr(8'h18, 32'h5A);
		chk("unmapped write", 32'(r), 32'h3);
		rdr(8'h18);
		chk("unmapped read", 32'(r), 32'h3);
		wr(`OFS_MODE_CONTROL, 32'h100);
		chk("write code", 32'(r), 32'h0);
		for (i = 0; i < 5; i++) begin
			p0 = (i == 0) ? 255 : $urandom_range(20, 1);
			p1 = $urandom_range(20, 1);
			o0 = (i == 0) ? 254 : $urandom_range(p0, 1);
			o1 = $urandom_range(p1, 1);
			wr(`OFS_ONTIME_ZERO, 32'(o0));
			wr(`OFS_ONTIME_ONE, 32'(o1));
			wr(`OFS_PERIOD_ONE, 32'(p1));
			wr(`OFS_PERIOD_ZERO, 32'(p0));
			#1 chk("restart", 32'(AUX_OUT0), 32'h1);
			repeat (3 * per_of(p0 > p1 ? p0 : p1) + 4) @(posedge REF_CLK);
			chk("per0", per0, per_of(p0));
			chk("hi0", hi0, 32'(2 * o0));
			chk("per1", per1, per_of(p1));
			chk("hi1", hi1, 32'(2 * o1));
		end
		wr(`OFS_ONTIME_ZERO, 32'h5);
		wr(`OFS_ONTIME_ONE, 32'h0);
		wr(`OFS_PERIOD_ZERO, 32'h3);
		wr(`OFS_PERIOD_ONE, 32'h3);
		repeat (2) @(posedge REF_CLK);
		for (i = 0; i < 20; i++) begin
			#1 chk("full and zero", 32'({AUX_OUT1, AUX_OUT0}), 32'h1);
			@(posedge REF_CLK);
		end
		wr(`OFS_ONTIME_ZERO, 32'h2);
		repeat (30) @(posedge REF_CLK);
		chk("late ontime", hi0, 32'h4);
		wr(`OFS_ONTIME_ONE, 32'h2);
		wr(`OFS_MODE_CONTROL, 32'h0);
		wr(`OFS_PERIOD_ONE, 32'h3);
		wr(`OFS_PERIOD_ZERO, 32'h9);
		repeat (74) @(posedge REF_CLK);
		chk("shared per0", per0, per_of(9));
		chk("shared per1", per1, per_of(9));
		chk("offset hi1", hi1, 32'h4);
		chk("offset", rise1 - rise0, per_of(3));
		report_and_stop();
	end
endmodule // dual_aux_pwm_timer_tb
